//--- rtl/tape_host_port.sv
`include "tape_port_defines.svh"

module tape_host_port #(
  parameter int CLK_MHZ = `CLK_MHZ,
  parameter int POC_CYCLES = `CYC_POC,
  parameter int STAT_MAX_CYCLES = `T_STAT_MAX_US * `CLK_MHZ,
  parameter int BLOCK_BYTES = 512,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host pins
  input wire logic request_pin,
  input wire logic xfer_pin,
  input wire logic online_pin,
  input wire logic host_reset_pin,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n,
  output logic ready,
  output logic ack,
  output logic exception,
  output logic dir_dev,
  // controller side
  input wire logic power_on_check,
  input wire logic poc_pass,
  input wire tape_port_pkg::cmd_class_t cmd_class,
  input wire logic motion_done,
  input wire logic read_last,
  input wire logic raise_exception,
  input wire logic [47:0] status_bytes,
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  // write data out of the port
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_data,
  // read data into the port
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data
);

  localparam int CW = 32;

  tape_port_pkg::host_ctl_t hs;
  tape_port_pkg::port_state_t st_reg, st_next;
  tape_port_pkg::cmd_class_t cls_reg, cls_next;
  logic [CW-1:0] tmr_reg, tmr_next;
  logic [CW-1:0] aux_reg, aux_next;
  logic [2:0] sidx_reg, sidx_next;
  logic [15:0] bcnt_reg, bcnt_next;
  logic [7:0] dout_reg, dout_next, cmd_reg, cmd_next;
  logic rdy_reg, rdy_next, ack_reg, ack_next;
  logic exc_reg, exc_next, dir_reg, dir_next;
  logic cmdv_reg, cmdv_next, req_d_reg;
  logic rst_seen;
  logic fifo_in_valid, fifo_in_ready, push_w;

  // pins come from the host's domain
  pin_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in({request_pin, xfer_pin, online_pin, host_reset_pin}),
    .level_out(hs)
  );

  // write bytes buffer here; a full fifo holds off ack
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(hs.reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(data_in),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

  assign fifo_in_valid = push_w;
  assign rst_seen = hs.reset;

  // outputs straight from flops
  assign ready = rdy_reg;
  assign ack = ack_reg;
  assign exception = exc_reg;
  assign dir_dev = dir_reg;
  assign data_out = dout_reg;
  assign data_oe_n = dir_reg ? 8'h00 : 8'hff;
  assign cmd_byte = cmd_reg;
  assign cmd_valid = cmdv_reg;

  // one handshake engine; tmr counts cycles since the last event
  always_comb begin
    st_next = st_reg;
    cls_next = cls_reg;
    tmr_next = (tmr_reg == '1) ? tmr_reg : tmr_reg + 1'b1;
    aux_next = (aux_reg == '1) ? aux_reg : aux_reg + 1'b1;
    sidx_next = sidx_reg;
    bcnt_next = bcnt_reg;
    dout_next = dout_reg;
    cmd_next = cmd_reg;
    rdy_next = rdy_reg;
    ack_next = ack_reg;
    exc_next = exc_reg || raise_exception;
    dir_next = dir_reg;
    cmdv_next = 1'b0;
    push_w = 1'b0;
    rd_ready = 1'b0;
    case (st_reg)
      tape_port_pkg::ST_RESET: begin
        // host holds reset past 25 us; we only wait for release
        if (!hs.reset) begin
          tmr_next = '0;
          if (power_on_check) begin
            exc_next = 1'b0;
            st_next = tape_port_pkg::ST_POC;
          end else begin
            rdy_next = 1'b1;
            st_next = tape_port_pkg::ST_IDLE;
          end
        end
      end
      tape_port_pkg::ST_POC: begin
        // check passes, or the window closes; either way report
        if (poc_pass || tmr_reg >= CW'(POC_CYCLES - 1)) begin
          exc_next = 1'b1;
          rdy_next = 1'b1;
          st_next = tape_port_pkg::ST_IDLE;
        end
      end
      tape_port_pkg::ST_IDLE: begin
        // command byte is valid when request rises
        if (hs.request && !req_d_reg) begin
          cmd_next = data_in;
          cmdv_next = 1'b1;
          tmr_next = '0;
          aux_next = '0;
          st_next = tape_port_pkg::ST_CMD_WAIT;
        end
      end
      tape_port_pkg::ST_CMD_WAIT: begin
        // class arrives from the controller a cycle after the byte
        if (aux_reg == CW'(1)) begin
          cls_next = cmd_class;
          rdy_next = 1'b0;
          if (cmd_class == tape_port_pkg::CMD_STATUS) begin
            exc_next = raise_exception; // a new exception in this cycle survives
          end
          tmr_next = '0;
        end else if (aux_reg > CW'(1)) begin
          // stays low while controller is busy; stretches allowed
          case (cls_reg)
            tape_port_pkg::CMD_STATUS: begin
              if (tmr_reg >= CW'(`CYC_EXC_CLR) && aux_reg >= CW'(`CYC_STAT_MIN)) begin
                rdy_next = 1'b1;
                st_next = tape_port_pkg::ST_CMD_REL;
              end
            end
            tape_port_pkg::CMD_SELECT: begin
              if (tmr_reg >= CW'(`CYC_CMD_MIN)) begin
                rdy_next = 1'b1;
                st_next = tape_port_pkg::ST_CMD_REL;
              end
            end
            tape_port_pkg::CMD_NONE: begin
              if (tmr_reg >= CW'(STAT_MAX_CYCLES)) begin
                rdy_next = 1'b1;
                st_next = tape_port_pkg::ST_CMD_REL;
              end
            end
            default: begin
              if (tmr_reg >= CW'(`CYC_STAT_MIN)) begin
                rdy_next = 1'b1;
                st_next = tape_port_pkg::ST_CMD_REL;
              end
            end
          endcase
        end
      end
      tape_port_pkg::ST_CMD_REL: begin
        // ready falls 20-100 us after request falls
        if (hs.request) begin
          tmr_next = '0;
        end else if (tmr_reg == CW'(`CYC_REL_MIN)) begin
          rdy_next = 1'b0;
          tmr_next = '0;
          bcnt_next = '0;
          case (cls_reg)
            tape_port_pkg::CMD_STATUS: begin
              sidx_next = '0;
              st_next = tape_port_pkg::ST_STAT_GAP;
            end
            tape_port_pkg::CMD_WRITE: begin
              st_next = tape_port_pkg::ST_WR_XFER;
            end
            tape_port_pkg::CMD_READ: begin
              dir_next = 1'b1;
              st_next = tape_port_pkg::ST_RD_OFFER;
            end
            tape_port_pkg::CMD_MOTION: begin
              st_next = tape_port_pkg::ST_MOTION;
            end
            default: begin
              st_next = tape_port_pkg::ST_END;
            end
          endcase
        end
      end
      tape_port_pkg::ST_STAT_GAP: begin
        // turn bus and present the byte, then ready
        dir_next = 1'b1;
        dout_next = status_bytes[8*(5 - 32'(sidx_reg)) +: 8];
        if (tmr_reg >= CW'(`CYC_REL_MIN)) begin
          rdy_next = 1'b1;
          st_next = tape_port_pkg::ST_STAT_BYTE;
        end
      end
      tape_port_pkg::ST_STAT_BYTE: begin
        // byte stays on the bus while request is high
        if (hs.request) begin
          rdy_next = 1'b0;
          st_next = tape_port_pkg::ST_STAT_REQ;
        end
      end
      tape_port_pkg::ST_STAT_REQ: begin
        if (!hs.request) begin
          tmr_next = '0;
          if (sidx_reg == 3'(`STATUS_BYTES - 1)) begin
            dir_next = 1'b0;
            st_next = tape_port_pkg::ST_END;
          end else begin
            sidx_next = sidx_reg + 1'b1;
            st_next = tape_port_pkg::ST_STAT_GAP;
          end
        end
      end
      tape_port_pkg::ST_WR_XFER: begin
        // gap after last ack of a block before ready
        if (!hs.online) begin
          st_next = tape_port_pkg::ST_END;
        end else if (!rdy_reg && tmr_reg >= CW'(`CYC_GAP) && bcnt_reg == '0) begin
          rdy_next = 1'b1;
        end else if (hs.xfer && fifo_in_ready) begin
          push_w = 1'b1;
          rdy_next = 1'b0;
          ack_next = 1'b1;
          st_next = tape_port_pkg::ST_WR_ACK;
        end
      end
      tape_port_pkg::ST_WR_ACK: begin
        if (!hs.xfer) begin
          ack_next = 1'b0;
          tmr_next = '0;
          bcnt_next = (bcnt_reg == 16'(BLOCK_BYTES - 1)) ? '0 : bcnt_reg + 1'b1;
          st_next = tape_port_pkg::ST_WR_XFER;
        end
      end
      tape_port_pkg::ST_RD_OFFER: begin
        // next byte on bus, ready only at block start
        if (read_last || !hs.online) begin
          exc_next = 1'b1;
          st_next = tape_port_pkg::ST_END;
        end else if (rd_valid && (bcnt_reg != '0 || tmr_reg >= CW'(`CYC_GAP))) begin
          rd_ready = 1'b1;
          dout_next = rd_data;
          rdy_next = (bcnt_reg == '0);
          tmr_next = '0;
          st_next = tape_port_pkg::ST_RD_ACK;
        end
      end
      tape_port_pkg::ST_RD_ACK: begin
        if (tmr_reg >= CW'(`CYC_ACK_SETUP)) begin
          ack_next = 1'b1;
          st_next = tape_port_pkg::ST_RD_XFER;
        end
      end
      tape_port_pkg::ST_RD_XFER: begin
        if (hs.xfer) begin
          rdy_next = 1'b0;
          ack_next = 1'b0;
        end else if (!ack_reg) begin
          tmr_next = '0;
          bcnt_next = (bcnt_reg == 16'(BLOCK_BYTES - 1)) ? '0 : bcnt_reg + 1'b1;
          st_next = tape_port_pkg::ST_RD_OFFER;
        end
      end
      tape_port_pkg::ST_MOTION: begin
        // ready returns once motion ends, 20 us after it fell
        if (motion_done && tmr_reg >= CW'(`CYC_REL_MIN)) begin
          rdy_next = 1'b1;
          st_next = tape_port_pkg::ST_IDLE;
        end
      end
      tape_port_pkg::ST_END: begin
        // bus back to host, then ready for a new command
        dir_next = 1'b0;
        ack_next = 1'b0;
        if (!dir_reg && tmr_reg >= CW'(`CYC_REL_MIN)) begin
          rdy_next = 1'b1;
          cls_next = tape_port_pkg::CMD_NONE;
          st_next = tape_port_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next = tape_port_pkg::ST_RESET;
      end
    endcase
    // host reset overrides the state, handshake, direction and fifo push: quiet port, exception up
    if (rst_seen) begin
      st_next = tape_port_pkg::ST_RESET;
      cls_next = tape_port_pkg::CMD_NONE;
      rdy_next = 1'b0;
      ack_next = 1'b0;
      exc_next = 1'b1;
      dir_next = 1'b0;
      push_w = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= tape_port_pkg::ST_RESET;
      cls_reg <= tape_port_pkg::CMD_NONE;
      tmr_reg <= '0;
      aux_reg <= '0;
      sidx_reg <= '0;
      bcnt_reg <= '0;
      dout_reg <= 8'h00;
      cmd_reg <= 8'h00;
      rdy_reg <= 1'b0;
      ack_reg <= 1'b0;
      exc_reg <= 1'b1;
      dir_reg <= 1'b0;
      cmdv_reg <= 1'b0;
      req_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cls_reg <= cls_next;
      tmr_reg <= tmr_next;
      aux_reg <= aux_next;
      sidx_reg <= sidx_next;
      bcnt_reg <= bcnt_next;
      dout_reg <= dout_next;
      cmd_reg <= cmd_next;
      rdy_reg <= rdy_next;
      ack_reg <= ack_next;
      exc_reg <= exc_next;
      dir_reg <= dir_next;
      cmdv_reg <= cmdv_next;
      req_d_reg <= hs.request;
    end
  end

endmodule

//--- rtl/tape_port_defines.svh
`ifndef TAPE_PORT_DEFINES_SVH
`define TAPE_PORT_DEFINES_SVH

// clock rate and derived cycle counts
`define CLK_MHZ 50
`define T_DROP_US 1
`define T_EXC_US 3
`define T_EXC_CLR_US 10
`define T_STAT_MIN_US 20
`define T_STAT_MAX_US 500
`define T_CMD_MIN_US 50
`define T_REL_MIN_US 20
`define T_REL_MAX_US 100
`define T_BLOCK_GAP_US 100
`define T_ACK_SETUP_NS 70
`define T_POC_S 5
// least times round up, longest times round down
`define CYC_DROP ((`T_DROP_US * `CLK_MHZ) - 2)
`define CYC_EXC_CLR (`T_EXC_CLR_US * `CLK_MHZ + 1)
`define CYC_STAT_MIN (`T_STAT_MIN_US * `CLK_MHZ + 1)
`define CYC_CMD_MIN (`T_CMD_MIN_US * `CLK_MHZ + 1)
`define CYC_REL_MIN (`T_REL_MIN_US * `CLK_MHZ + 1)
`define CYC_GAP (`T_BLOCK_GAP_US * `CLK_MHZ + 1)
`define CYC_ACK_SETUP ((`T_ACK_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define CYC_POC (`T_POC_S * 1000000 * `CLK_MHZ)
`define STATUS_BYTES 6

`endif

//--- rtl/tape_port_pkg.sv
package tape_port_pkg;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_POC = 4'h1,
    ST_IDLE = 4'h2,
    ST_CMD_WAIT = 4'h3,
    ST_CMD_REL = 4'h4,
    ST_STAT_GAP = 4'h5,
    ST_STAT_BYTE = 4'h6,
    ST_STAT_REQ = 4'h7,
    ST_WR_XFER = 4'h8,
    ST_WR_ACK = 4'h9,
    ST_RD_OFFER = 4'ha,
    ST_RD_ACK = 4'hb,
    ST_RD_XFER = 4'hc,
    ST_MOTION = 4'hd,
    ST_END = 4'he
  } port_state_t;

  // command classes decoded by the controller firmware side
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_STATUS = 3'h1,
    CMD_SELECT = 3'h2,
    CMD_MOTION = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5
  } cmd_class_t;

  // host-side pins as seen after synchronisation
  typedef struct packed {
    logic request;
    logic xfer;
    logic online;
    logic reset;
  } host_ctl_t;

  // device-driven handshake pins
  typedef struct packed {
    logic ready;
    logic ack;
    logic exception;
    logic dir_dev;
  } dev_ctl_t;

endpackage

//--- rtl/pin_sync.sv
// three flops; a change counts once the last two agree
module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [WIDTH-1:0] lvl_next;

  // keep the old level while the two late flops disagree
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s2_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;

endmodule

//--- rtl/byte_fifo.sv
// flip-flop fifo, valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers wrap at depth, which need not be a power of two
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    if (flush) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset; only written on push
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

endmodule

//--- verif/tape_port_properties.sv
module tape_port_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host pins, and the controller's power-on check
  input wire logic request_pin,
  input wire logic xfer_pin,
  input wire logic host_reset_pin,
  input wire logic power_on_check,
  // device pins
  input wire logic ready,
  input wire logic ack,
  input wire logic exception,
  input wire logic dir_dev,
  input wire logic [7:0] data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // cycles since request fell with ready up; a counter, since the window is long
  logic [11:0] rel_cnt;
  always_ff @(posedge clk) begin
    if (!nrst || !ready) begin
      rel_cnt <= 12'h000;
    end else if ($fell(request_pin)) begin
      rel_cnt <= 12'h001;
    end else if (rel_cnt != 12'h000) begin
      rel_cnt <= rel_cnt + 12'h001;
    end
  end

  // host reset: sync latency eats into the 1 us and 3 us budgets
  a_reset_drops_hs:
    assert property ($rose(host_reset_pin) |-> ##[1:50] (!ready && !ack))
    else $error("handshake not cleared by host reset");
  a_reset_exc_dir:
    assert property ($rose(host_reset_pin) |-> ##[1:150] (exception && !dir_dev))
    else $error("exception or direction wrong after host reset");
  a_poc_exc_drop:
    assert property ($fell(host_reset_pin) && power_on_check |-> ##[1:50] !exception)
    else $error("exception kept during power-on check");
  // command and status handshake
  a_req_drops_rdy:
    assert property ($rose(request_pin) && ready |-> ##[1:50] !ready)
    else $error("ready not dropped after request");
  a_rdy_hold_min:
    assert property (rel_cnt != 12'h000 && rel_cnt < 12'h3de |=> ready)
    else $error("ready released too soon after request fell");
  a_rdy_release:
    assert property (rel_cnt < 12'h454)
    else $error("ready release window missed");
  // data strobes
  a_xfer_drops_rdy:
    assert property ($rose(xfer_pin) && ready |-> ##[1:50] !ready)
    else $error("ready not dropped after xfer");
  a_wr_ack_clear:
    assert property ($fell(xfer_pin) && ack && !dir_dev |-> ##[1:150] !ack)
    else $error("write ack stuck after xfer fell");
  a_rd_ack_drop:
    assert property ($rose(xfer_pin) && dir_dev |-> ##[1:50] !ack)
    else $error("read ack stuck after xfer");
  a_rd_ack_setup:
    assert property ($rose(ready) && dir_dev |-> !ack [*4])
    else $error("ack too soon after ready");
  a_oe_follows_dir:
    assert property (data_oe_n == (dir_dev ? 8'h00 : 8'hff))
    else $error("bus enable disagrees with direction");

  c_status_turn: cover property ($fell(dir_dev));
  c_write_ack: cover property ($rose(ack) && !dir_dev);
  c_read_ack: cover property ($rose(ack) && dir_dev);
endmodule

bind tape_host_port tape_port_properties checks (
  .clk(clk), .nrst(nrst), .request_pin(request_pin), .xfer_pin(xfer_pin),
  .host_reset_pin(host_reset_pin), .power_on_check(power_on_check), .ready(ready),
  .ack(ack), .exception(exception), .dir_dev(dir_dev), .data_oe_n(data_oe_n));

//--- verif/host_adapter_model.sv
module host_adapter_model (
  // clock
  input wire logic clk,
  // pins towards the port
  output logic request_pin,
  output logic xfer_pin,
  output logic online_pin,
  output logic host_reset_pin,
  output logic [7:0] data_in,
  // pins from the port
  input wire logic ready,
  input wire logic ack,
  input wire logic exception,
  input wire logic dir_dev,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv;
  logic drv_en;
  logic [3:0] seen;

  // released bus shows the inverse of the last byte, never a stale copy
  assign data_in = (data_oe_n == 8'h00) ? data_out : (drv_en ? drv : ~drv);
  assign seen = {ready, ack, dir_dev, exception};

  initial begin
    request_pin = 1'b0;
    xfer_pin = 1'b0;
    online_pin = 1'b0;
    host_reset_pin = 1'b0;
    drv = 8'h00;
    drv_en = 1'b0;
  end

  // bounded wait, sampled on the falling edge where levels are settled
  task automatic wait_pin(input int idx, input logic v, input int lim, output int n);
    for (n = 0; n < lim && seen[idx] !== v; n++) @(negedge clk);
  endtask

  // reset held past its minimum width
  task automatic host_reset();
    @(posedge clk);
    host_reset_pin <= 1'b1;
    repeat (1300) @(posedge clk);
    host_reset_pin <= 1'b0;
  endtask

  // byte rides with request until ready answers; lo counts ready low
  task automatic command(input logic [7:0] code, output int lo);
    int n;
    wait_pin(3, 1'b1, 60000, n);
    @(posedge clk);
    drv <= code;
    drv_en <= 1'b1;
    request_pin <= 1'b1;
    wait_pin(3, 1'b0, 100, n);
    wait_pin(3, 1'b1, 60000, lo);
    @(posedge clk);
    request_pin <= 1'b0;
    drv_en <= 1'b0;
    // the answer stands until the release window closes
    wait_pin(3, 1'b0, 1200, n);
  endtask

  // take a status byte on ready, then request it away
  task automatic status_byte(output logic [7:0] b);
    int n;
    wait_pin(3, 1'b1, 60000, n);
    b = data_out;
    @(posedge clk);
    request_pin <= 1'b1;
    repeat (1050) @(posedge clk);
    request_pin <= 1'b0;
  endtask

  // xfer strobe, host byte presented with it
  task automatic strobe(input logic v, input logic [7:0] b);
    @(posedge clk);
    xfer_pin <= v;
    drv <= b;
    drv_en <= v;
  endtask

  task automatic set_online(input logic v);
    @(posedge clk);
    online_pin <= v;
  endtask
endmodule

//--- verif/tape_host_port_handshake_bench.sv
module tape_host_port_handshake_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHECK(got, exp) \
    begin \
      compares++; \
      if ((got) !== (exp)) begin \
        failures++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
      end \
    end
  localparam int RDY = 3;
  localparam int ACK = 2;
  localparam int DIR = 1;
  localparam int EXC = 0;
  typedef struct {
    tape_port_pkg::cmd_class_t cls;
    logic [7:0] code;
    int lo_min;
  } row_t;
  row_t rows [3];
  logic clk, nrst, request_pin, xfer_pin, online_pin, host_reset_pin;
  logic [7:0] data_in, data_out, data_oe_n, cmd_byte, cmd_seen, wr_data, rd_data;
  logic ready, ack, exception, dir_dev, power_on_check, poc_pass, motion_done;
  logic read_last, raise_exception, cmd_valid, wr_valid, wr_ready, rd_valid, rd_ready;
  logic [47:0] status_bytes;
  tape_port_pkg::cmd_class_t cmd_class;
  logic [7:0] wq [$];
  int failures, compares, lo, n;

  tape_host_port #(.POC_CYCLES(200), .STAT_MAX_CYCLES(1500), .BLOCK_BYTES(12)) DUT (
    .clk(clk), .nrst(nrst), .request_pin(request_pin), .xfer_pin(xfer_pin),
    .online_pin(online_pin), .host_reset_pin(host_reset_pin), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .ready(ready), .ack(ack),
    .exception(exception), .dir_dev(dir_dev), .power_on_check(power_on_check),
    .poc_pass(poc_pass), .cmd_class(cmd_class), .motion_done(motion_done),
    .read_last(read_last), .raise_exception(raise_exception),
    .status_bytes(status_bytes), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));

  host_adapter_model host (
    .clk(clk), .request_pin(request_pin), .xfer_pin(xfer_pin), .online_pin(online_pin),
    .host_reset_pin(host_reset_pin), .data_in(data_in), .ready(ready), .ack(ack),
    .exception(exception), .dir_dev(dir_dev), .data_out(data_out),
    .data_oe_n(data_oe_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // latched command, drained write bytes, read source stepping on accept
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) cmd_seen <= cmd_byte;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back(wr_data);
    if (rd_ready === 1'b1 && rd_valid === 1'b1) rd_data <= rd_data + 8'h01;
  end

  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // whole status sequence, six bytes then bus back to the host
  task automatic read_status();
    logic [7:0] b;
    int lo2;
    @(posedge clk) cmd_class <= tape_port_pkg::CMD_STATUS;
    host.command(8'hc0, lo2);
    `CHECK({exception, lo2 >= 990 && lo2 <= 25000}, 2'b01)
    for (int i = 0; i < 6; i++) begin
      host.status_byte(b);
      `CHECK({dir_dev, data_oe_n, b}, {1'b1, 8'h00, status_bytes[47 - 8 * i -: 8]})
    end
    host.wait_pin(RDY, 1'b1, 30000, lo2);
    `CHECK({ready, dir_dev}, 2'b10)
  endtask

  // about 82k cycles expected; a hang is cut short before 100k
  initial begin
    repeat (98000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    {power_on_check, poc_pass, read_last, raise_exception, wr_ready, rd_valid} = 6'h00;
    motion_done = 1'b1;
    cmd_class = tape_port_pkg::CMD_NONE;
    status_bytes = 48'h0123456789ab;
    rd_data = 8'h50;
    failures = 0;
    compares = 0;
    rows = '{'{tape_port_pkg::CMD_SELECT, 8'h01, 2499},
             '{tape_port_pkg::CMD_MOTION, 8'h21, 999},
             '{tape_port_pkg::CMD_NONE, 8'h33, 1499}};
    repeat (16) @(posedge clk);
    `CHECK({ready, ack, exception, dir_dev}, 4'b0010)
    nrst <= 1'b1;
    host.host_reset();
    host.wait_pin(RDY, 1'b1, 200, n);
    `CHECK(exception, 1'b1)
    read_status();
    // ordinary commands: ready low window, then release and re-raise
    foreach (rows[i]) begin
      @(posedge clk);
      cmd_class <= rows[i].cls;
      motion_done <= 1'b0;
      host.command(rows[i].code, lo);
      `CHECK({cmd_seen, lo >= rows[i].lo_min && lo <= 25000}, {rows[i].code, 1'b1})
      host.wait_pin(RDY, 1'b0, 1200, n);
      @(posedge clk) motion_done <= 1'b1;
      host.wait_pin(RDY, 1'b1, 30000, n);
      `CHECK({ready, n >= 998}, 2'b11)
    end
    // write with the drain stalled: the ninth byte must wait for room
    @(posedge clk) cmd_class <= tape_port_pkg::CMD_WRITE;
    host.set_online(1'b1);
    host.command(8'h40, lo);
    host.wait_pin(RDY, 1'b1, 30000, n);
    for (int i = 0; i < 12; i++) begin
      host.strobe(1'b1, 8'h10 + 8'(i));
      host.wait_pin(ACK, 1'b1, 300, n);
      if (i == 8) begin
        `CHECK(ack, 1'b0)
        @(posedge clk) wr_ready <= 1'b1;
        host.wait_pin(ACK, 1'b1, 300, n);
      end
      `CHECK({ack, ready}, 2'b10)
      host.strobe(1'b0, 8'h10 + 8'(i));
      host.wait_pin(ACK, 1'b0, 300, n);
      `CHECK(ack, 1'b0)
    end
    host.wait_pin(RDY, 1'b1, 30000, n);
    `CHECK(n > 5000, 1'b1)
    `CHECK(wq.size(), 12)
    foreach (wq[i]) `CHECK(wq[i], 8'h10 + 8'(i))
    host.set_online(1'b0);
    // online low must outlast the pin filter or the drop is never seen
    repeat (8) @(posedge clk);
    // read three bytes, then the source reports the end
    @(posedge clk) cmd_class <= tape_port_pkg::CMD_READ;
    host.set_online(1'b1);
    host.command(8'h80, lo);
    @(posedge clk) rd_valid <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      host.wait_pin(ACK, 1'b1, 30000, n);
      `CHECK({dir_dev, data_out}, {1'b1, 8'h50 + 8'(i)})
      host.strobe(1'b1, 8'h00);
      host.wait_pin(ACK, 1'b0, 100, n);
      `CHECK({ack, ready}, 2'b00)
      host.strobe(1'b0, 8'h00);
    end
    @(posedge clk) read_last <= 1'b1;
    host.wait_pin(DIR, 1'b0, 30000, n);
    `CHECK(exception, 1'b1)
    @(posedge clk) read_last <= 1'b0;
    host.set_online(1'b0);
    read_status();
    // exception raised from the controller side is sticky until status
    @(posedge clk) raise_exception <= 1'b1;
    status_bytes <= 48'hfedcba987654;
    @(posedge clk) raise_exception <= 1'b0;
    host.wait_pin(EXC, 1'b1, 20, n);
    `CHECK(exception, 1'b1)
    read_status();
    // reset with the power-on check: exception drops, then returns
    @(posedge clk) power_on_check <= 1'b1;
    host.host_reset();
    host.wait_pin(EXC, 1'b0, 50, n);
    `CHECK(exception, 1'b0)
    host.wait_pin(EXC, 1'b1, 400, n);
    `CHECK({exception, n <= 300}, 2'b11)
    // again, with the check ending early through its pass input
    host.host_reset();
    host.wait_pin(EXC, 1'b0, 50, n);
    @(posedge clk) poc_pass <= 1'b1;
    host.wait_pin(EXC, 1'b1, 20, n);
    `CHECK({exception, n < 10}, 2'b11)
    end_of_test();
  end
endmodule
